/* rtl/i2c_master_transmit.v */
// Purpose: I2C master transmit path with Start, Restart, Stop and byte shifting
// Assumes: Open-drain SDA and SCL, AXI4-Lite register access, 25 MHz sys_clk
// Notes: SCL and SDA inputs pass two flip-flops; SCL high phase waits for stretching
`timescale 1ns/1ps
`include "i2c_mtx_regs.vh"

module i2c_master_transmit
(
   input wire sys_clk,
   input wire nrst,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire scl_i,
   output reg scl_o,
   output reg scl_oe,
   input wire sda_i,
   output reg sda_o,
   output reg sda_oe,
   output reg irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // States
   localparam IDLE = 4'h0; // Bus free, both lines released
   localparam ST_A = 4'h1; // Start: both released, wait one period
   localparam ST_B = 4'h2; // Start: SDA low, start hold time
   localparam ST_C = 4'h3; // Start: SCL low
   localparam RS_A = 4'h4; // Restart: release SDA with SCL low
   localparam SP_A = 4'h5; // Stop: SDA low with SCL low
   localparam SP_B = 4'h6; // Stop: SCL released
   localparam SP_C = 4'h7; // Stop: SDA released
   localparam BIT_LO = 4'h8; // Bit low phase
   localparam BIT_HI = 4'h9; // Bit high phase
   localparam HOLD = 4'hA; // Clock suspended, SCL held low

   reg [3:0] state; // Sequencer state
   reg [7:0] tx_buffer_reg; // Last accepted buffer value
   reg [7:0] byte_shift_register; // Outgoing bits, MSB first
   reg [3:0] bit_cnt; // Bit within byte, 8 is acknowledge
   reg sda_set; // Bit placed on SDA in this low phase
   reg ack_taken; // Acknowledge already sampled
   reg buffer_full_flag; // Buffer holds an unsent byte
   reg ack_status_bit; // High when slave did not acknowledge
   reg start_request_bit; // Start pending
   reg restart_request_bit; // Restart pending
   reg stop_request_bit; // Stop pending
   reg [1:0] irq_status; // Sticky serial_irq_flag and write_collision_flag
   reg [1:0] irq_mask; // Enables for irq_status
   reg [7:0] baud_reload; // Baud generator reload value
   reg scl_meta; // Synchroniser first stage
   reg scl_sync; // Synchronised SCL
   reg sda_meta; // Synchroniser first stage
   reg sda_sync; // Synchronised SDA
   reg aw_held; // Write address captured
   reg w_held; // Write data captured
   reg [7:0] aw_addr; // Captured write address
   reg [7:0] w_data; // Captured low data byte
   reg w_lane0; // Captured strobe of lane 0
   wire wr_go; // Perform the captured write this cycle
   wire wr_hit; // Write address is mapped
   wire tick; // Baud rollover
   wire baud_clr; // Hold baud generator at reload
   wire serial_irq_flag; // Event completion flag
   wire write_collision_flag; // Collision flag
   wire shifting; // A bus sequence is under way

   assign serial_irq_flag = irq_status[`IRQ_SERIAL_BIT];
   assign write_collision_flag = irq_status[`IRQ_WRITE_COLLISION_FLAG_BIT];
   assign shifting = (state != IDLE) && (state != HOLD);
   assign wr_go = aw_held & w_held & ~s_axi_bvalid;
   assign wr_hit = (aw_addr[7:2] <= `OFS_BAUD_RELOAD >> 2) && (aw_addr[1:0] == 2'h0);

   // Suspended outside sequences; while SCL is released but held low by a slave,
   // the count waits so the high phase is measured from the real rising edge
   assign baud_clr = ~shifting | (~scl_oe & ~scl_sync);

   ////////////////////////////////////////////////////////////////////////////////
   // Baud generator
   baud_gen u_baud
   (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .clr(baud_clr),
      .reload(baud_reload),
      .tick(tick)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // Two-flop synchronisers for the bus lines
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         scl_meta <= 1'b1;
         scl_sync <= 1'b1;
         sda_meta <= 1'b1;
         sda_sync <= 1'b1;
      end
      else
      begin
         scl_meta <= scl_i;
         scl_sync <= scl_meta;
         sda_meta <= sda_i;
         sda_sync <= sda_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channels: address and data taken in either order
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 8'h00;
         w_data <= 8'h00;
         w_lane0 <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `RESP_OKAY;
      end
      else
      begin
         // Ready is offered one cycle ahead of capture, dropped once captured
         s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready) & ~s_axi_bvalid;
         s_axi_wready <= ~w_held & ~(s_axi_wvalid & s_axi_wready) & ~s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata[7:0];
            w_lane0 <= s_axi_wstrb[0];
         end
         if (wr_go)
         begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel: data one cycle after the address is taken
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~s_axi_rvalid & ~(s_axi_arvalid & s_axi_arready);
         if (s_axi_arvalid && s_axi_arready)
         begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (s_axi_araddr)
               `OFS_TX_BUFFER: s_axi_rdata <= {24'h000000, tx_buffer_reg};
               `OFS_CONTROL2: s_axi_rdata <= {25'h0, ack_status_bit, 3'h0,
                  stop_request_bit, restart_request_bit, start_request_bit};
               `OFS_STATUS: s_axi_rdata <= {29'h0, shifting, 1'b0, buffer_full_flag};
               `OFS_IRQ_STATUS: s_axi_rdata <= {30'h0, irq_status};
               `OFS_IRQ_MASK: s_axi_rdata <= {30'h0, irq_mask};
               `OFS_BAUD_RELOAD: s_axi_rdata <= {24'h000000, baud_reload};
               default:
               begin
                  // Unmapped address answers with an error and zero data
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= `RESP_SLVERR;
               end
            endcase
         end
         else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Registers and bus sequencer; later assignments win, so sequencer updates beat same-cycle software writes
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         state <= IDLE;
         tx_buffer_reg <= 8'h00;
         byte_shift_register <= 8'h00;
         bit_cnt <= 4'h0;
         sda_set <= 1'b0;
         ack_taken <= 1'b0;
         buffer_full_flag <= 1'b0;
         ack_status_bit <= 1'b0;
         start_request_bit <= 1'b0;
         restart_request_bit <= 1'b0;
         stop_request_bit <= 1'b0;
         irq_status <= 2'h0;
         irq_mask <= `IRQ_MASK_RST;
         baud_reload <= `BAUD_RELOAD_RST;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         scl_o <= 1'b0;
         sda_o <= 1'b0;
         irq <= |(irq_status & irq_mask);
         // Software register writes
         if (wr_go && w_lane0)
         begin
            case (aw_addr)
               `OFS_TX_BUFFER:
               begin
                  if (shifting)
                     irq_status[`IRQ_WRITE_COLLISION_FLAG_BIT] <= 1'b1;
                  else
                  begin
                     tx_buffer_reg <= w_data;
                     byte_shift_register <= w_data;
                     buffer_full_flag <= 1'b1;
                     bit_cnt <= 4'h0;
                     sda_set <= 1'b0;
                     ack_taken <= 1'b0;
                     scl_oe <= 1'b1;
                     state <= BIT_LO;
                  end
               end
               `OFS_CONTROL2:
               begin
                  start_request_bit <= start_request_bit | w_data[`CTL_START_BIT];
                  restart_request_bit <= restart_request_bit | w_data[`CTL_RESTART_BIT];
                  stop_request_bit <= stop_request_bit | w_data[`CTL_STOP_BIT];
               end
               `OFS_IRQ_STATUS:
                  irq_status <= irq_status & ~w_data[1:0];
               `OFS_IRQ_MASK:
                  irq_mask <= w_data[1:0];
               `OFS_BAUD_RELOAD:
                  baud_reload <= w_data;
               default:
                  irq_mask <= irq_mask;
            endcase
         end
         // Sequencer
         case (state)
            IDLE:
               if (start_request_bit)
                  state <= ST_A;
            HOLD:
               if (restart_request_bit)
                  state <= RS_A;
               else if (stop_request_bit)
               begin
                  sda_oe <= 1'b1;
                  state <= SP_A;
               end
            RS_A:
            begin
               sda_oe <= 1'b0;
               if (tick)
               begin
                  scl_oe <= 1'b0;
                  state <= ST_A;
               end
            end
            ST_A:
               if (tick)
               begin
                  sda_oe <= 1'b1;
                  state <= ST_B;
               end
            ST_B:
               if (tick)
               begin
                  scl_oe <= 1'b1;
                  state <= ST_C;
               end
            ST_C:
               if (tick)
               begin
                  start_request_bit <= 1'b0;
                  restart_request_bit <= 1'b0;
                  irq_status[`IRQ_SERIAL_BIT] <= 1'b1;
                  state <= HOLD;
               end
            SP_A:
               if (tick)
               begin
                  scl_oe <= 1'b0;
                  state <= SP_B;
               end
            SP_B:
               if (tick)
               begin
                  sda_oe <= 1'b0;
                  state <= SP_C;
               end
            SP_C:
               if (tick)
               begin
                  stop_request_bit <= 1'b0;
                  irq_status[`IRQ_SERIAL_BIT] <= 1'b1;
                  state <= IDLE;
               end
            BIT_LO:
            begin
               scl_oe <= 1'b1;
               // Change SDA only once the pin is seen low, giving hold time
               if (!scl_sync && !sda_set)
               begin
                  sda_oe <= (bit_cnt == `BYTE_ACK_BIT) ? 1'b0 : ~byte_shift_register[7];
                  sda_set <= 1'b1;
               end
               if (tick && sda_set)
               begin
                  scl_oe <= 1'b0;
                  state <= BIT_HI;
               end
            end
            BIT_HI:
            begin
               if (scl_sync && !ack_taken && bit_cnt == `BYTE_ACK_BIT)
               begin
                  ack_status_bit <= sda_sync;
                  ack_taken <= 1'b1;
               end
               if (tick)
               begin
                  scl_oe <= 1'b1;
                  sda_set <= 1'b0;
                  if (bit_cnt == `BYTE_LAST_BIT)
                     buffer_full_flag <= 1'b0;
                  if (bit_cnt == `BYTE_ACK_BIT)
                  begin
                     irq_status[`IRQ_SERIAL_BIT] <= 1'b1;
                     state <= HOLD;
                  end
                  else
                  begin
                     bit_cnt <= bit_cnt + 4'h1;
                     byte_shift_register <= {byte_shift_register[6:0], 1'b0};
                     state <= BIT_LO;
                  end
               end
            end
            default:
               state <= IDLE;
         endcase
      end
   end

endmodule // i2c_master_transmit

/* rtl/i2c_mtx_regs.vh */
// Purpose: Register map, field positions and reset values of the I2C master transmitter
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus, one aligned word per register
// Notes: Definitions only, no logic
`ifndef I2C_MTX_REGS_VH
`define I2C_MTX_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define OFS_TX_BUFFER 8'h00
`define OFS_CONTROL2 8'h04
`define OFS_STATUS 8'h08
`define OFS_IRQ_STATUS 8'h0C
`define OFS_IRQ_MASK 8'h10
`define OFS_BAUD_RELOAD 8'h14

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define CTL_START_BIT 0
`define CTL_RESTART_BIT 1
`define CTL_STOP_BIT 2
`define CTL_ACK_STAT_BIT 6
`define STAT_BF_BIT 0
`define STAT_BUSY_BIT 2
`define IRQ_SERIAL_BIT 0
`define IRQ_WRITE_COLLISION_FLAG_BIT 1

////////////////////////////////////////////////////////////////////////////////
// Reset values and answers
`define BAUD_RELOAD_RST 8'h09
`define IRQ_MASK_RST 2'h0
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`define BYTE_LAST_BIT 4'h7
`define BYTE_ACK_BIT 4'h8

`endif

/* rtl/baud_gen.v */
// Purpose: Baud generator giving one tick per rollover of a programmable reload count
// Assumes: Single clock domain, reload stable while running
// Notes: Tick period is reload plus one clock cycles
`timescale 1ns/1ps

module baud_gen
(
   input wire sys_clk,
   input wire nrst,
   input wire clr,
   input wire [7:0] reload,
   output wire tick
);

   reg [7:0] count; // Down counter toward rollover

   ////////////////////////////////////////////////////////////////////////////////
   // Tick is combinational so the state machine moves in the rollover cycle itself
   assign tick = ~clr & (count == 8'h00);

   // Count down, reload on rollover or while held cleared
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
         count <= 8'h00;
      else if (clr || count == 8'h00)
         count <= reload;
      else
         count <= count - 8'h01;
   end

endmodule // baud_gen

/* verification/i2c_mtx_checker.sv */
// Purpose: Bus answer and wire timing checks for the I2C master transmitter
// Assumes: Write address and write data are offered in the same cycle
// Notes: Baud reload is shadowed from register writes seen at the ports
`timescale 1ns/1ps
`include "i2c_mtx_regs.vh"

module i2c_mtx_checker
(
   input wire sys_clk,
   input wire nrst,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [1:0] s_axi_rresp,
   input wire s_axi_rvalid,
   input wire scl_o,
   input wire scl_oe,
   input wire sda_o,
   input wire sda_oe
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   ////////////////////////////////////////
   reg [7:0] reload; // Shadow of the baud reload
   reg prev_oe; // SCL drive one sample back
   reg [8:0] run; // Samples SCL drive kept its level
   wire wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   // Shadow reload and time each SCL phase; saturates so idle cannot wrap
   always @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         reload <= `BAUD_RELOAD_RST;
         prev_oe <= 1'b0;
         run <= 9'h000;
      end
      else
      begin
         if (wr_take && s_axi_awaddr == `OFS_BAUD_RELOAD)
            reload <= s_axi_wdata[7:0];
         prev_oe <= scl_oe;
         run <= (scl_oe != prev_oe) ? 9'h001 : run + {8'h00, run != 9'h1FF};
      end
   end
   ////////////////////////////////////////
   sequence wr_seq;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_seq;
      s_axi_arvalid && s_axi_arready;
   endsequence
   write_answer_a: assert property (wr_seq |-> ##[1:2] s_axi_bvalid)
      else $error("write answer late");
   bad_write_a: assert property (wr_seq ##0 (s_axi_awaddr > `OFS_BAUD_RELOAD)
      |-> ##[1:2] (s_axi_bvalid && s_axi_bresp == `RESP_SLVERR))
      else $error("unmapped write not refused");
   read_answer_a: assert property (ar_seq |=> s_axi_rvalid)
      else $error("read answer late");
   bad_read_a: assert property (ar_seq ##0 (s_axi_araddr > `OFS_BAUD_RELOAD)
      |=> s_axi_rvalid && s_axi_rresp == `RESP_SLVERR)
      else $error("unmapped read not refused");
   write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0)
      else $error("wire driven high");
   sda_move_a: assert property (($rose(sda_oe) || $fell(sda_oe)) && scl_oe
      |-> $past(scl_oe, 2))
      else $error("SDA moved before SCL was low");
   scl_low_a: assert property ($fell(scl_oe) |-> run >= {1'b0, reload} + 9'h001)
      else $error("SCL low phase short");
   scl_high_a: assert property ($rose(scl_oe) |-> run >= {1'b0, reload} + 9'h001)
      else $error("SCL high phase short");
endmodule // i2c_mtx_checker

bind i2c_master_transmit i2c_mtx_checker i2c_mtx_checker_i
(
   .sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
   .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe)
);

/* verification/i2c_slave_model.sv */
// Purpose: Behavioural addressed slave on the two-wire bus
// Assumes: Both wires pulled up, this model only pulls SDA low
// Notes: Captures every byte; a NACK on data is commanded by the bench
`timescale 1ns/1ps

module i2c_slave_model
#(
   parameter [6:0] ADDR = 7'h35
)
(
   input wire scl,
   input wire sda,
   input wire nack,
   output reg drive,
   output reg [7:0] rx_byte
);
   reg [7:0] shift; // Bits gathered so far
   reg [3:0] cnt; // Bits of this byte
   reg ack_ph; // Inside the ninth bit
   reg first; // Next byte is the address
   initial
   begin
      drive = 1'b0;
      rx_byte = 8'h00;
      shift = 8'h00;
      cnt = 4'h0;
      ack_ph = 1'b0;
      first = 1'b0;
   end
   // Start or repeated start: SDA falls while SCL is high
   always @(negedge sda)
      if (scl === 1'b1)
      begin
         cnt = 4'h0;
         ack_ph = 1'b0;
         first = 1'b1;
      end
   // Sample on SCL rise, first bit is the most significant
   always @(posedge scl)
      if (!ack_ph)
      begin
         shift = {shift[6:0], sda};
         cnt = cnt + 4'h1;
      end
   // Answer after the eighth bit, let go after the ninth
   always @(negedge scl)
      if (ack_ph)
      begin
         drive = 1'b0;
         ack_ph = 1'b0;
         cnt = 4'h0;
         first = 1'b0;
      end
      else if (cnt == 4'h8)
      begin
         rx_byte = shift;
         drive = first ? (shift[7:1] == ADDR) : !nack;
         ack_ph = 1'b1;
      end
endmodule // i2c_slave_model

/* verification/test_i2c_master_transmit.sv */
// Purpose: Self-checking bench for the I2C master transmitter
// Assumes: Slave model on a pulled-up two-wire bus
// Notes: Baud reload kept small so that bytes finish quickly
`timescale 1ns/1ps
`include "i2c_mtx_regs.vh"
`define CHK(n, e, g) \
   begin \
      samples_checked = samples_checked + 1; \
      if ((g) !== (e)) \
      begin \
         err_total = err_total + 1; \
         $display("unexpected %s exp %h got %h", n, e, g); \
      end \
   end

module test_i2c_master_transmit;
   localparam [6:0] SLV_ADDR = 7'h35; // Address the slave answers
   reg sys_clk = 1'b0;
   reg nrst = 1'b0;
   reg [7:0] s_axi_awaddr = 8'h00;
   reg s_axi_awvalid = 1'b0;
   reg [31:0] s_axi_wdata = 32'h0;
   reg [3:0] s_axi_wstrb = 4'hF;
   reg s_axi_wvalid = 1'b0;
   reg s_axi_bready = 1'b0;
   reg [7:0] s_axi_araddr = 8'h00;
   reg s_axi_arvalid = 1'b0;
   reg s_axi_rready = 1'b0;
   reg slv_nack = 1'b0; // Slave refuses data bytes
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire scl_o, scl_oe, sda_o, sda_oe, irq, slv_oe;
   wire [7:0] rx_byte;
   wire scl_w = ~scl_oe; // Pulled up unless pulled low
   wire sda_w = ~(sda_oe | slv_oe);
   integer err_total = 0;
   integer samples_checked = 0;
   integer seed = 52;
   integer cycles = 0;
   integer i;
   reg [31:0] rd; // Last read data
   reg [1:0] rs; // Last response code
   reg [7:0] b; // Byte under test
   always #20 sys_clk = ~sys_clk;
   ////////////////////////////////////////
   i2c_master_transmit i2c_master_transmit_i
   (
      .sys_clk(sys_clk), .nrst(nrst), .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq)
   );
   i2c_slave_model #(.ADDR(SLV_ADDR)) i2c_slave_model_i
   (
      .scl(scl_w), .sda(sda_w), .nack(slv_nack), .drive(slv_oe), .rx_byte(rx_byte)
   );
   ////////////////////////////////////////
   // Expected address byte: seven address bits then direction
   function [7:0] addr_byte(input [6:0] a, input rw);
      addr_byte = {a, rw};
   endfunction
   // Expected acknowledge status, one meaning no acknowledge
   function exp_ack(input adr, input [7:0] sent, input nak);
      exp_ack = adr ? (sent[7:1] != SLV_ADDR) : nak;
   endfunction
   // Register write; both channels offered together
   task axi_wr(input [7:0] a, input [31:0] d);
      reg aw_ok, w_ok;
      begin
         @(posedge sys_clk);
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
         aw_ok = 1'b0;
         w_ok = 1'b0;
         while (!(aw_ok && w_ok))
         begin
            @(posedge sys_clk);
            aw_ok = aw_ok | (s_axi_awvalid & s_axi_awready);
            w_ok = w_ok | (s_axi_wvalid & s_axi_wready);
            if (aw_ok)
               s_axi_awvalid <= 1'b0;
            if (w_ok)
               s_axi_wvalid <= 1'b0;
         end
         while (s_axi_bvalid !== 1'b1)
            @(posedge sys_clk);
         rs = s_axi_bresp;
         s_axi_bready <= 1'b0;
      end
   endtask
   // Register read
   task axi_rd(input [7:0] a);
      begin
         @(posedge sys_clk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         @(posedge sys_clk);
         while (s_axi_arready !== 1'b1)
            @(posedge sys_clk);
         s_axi_arvalid <= 1'b0;
         while (s_axi_rvalid !== 1'b1)
            @(posedge sys_clk);
         rd = s_axi_rdata;
         rs = s_axi_rresp;
         s_axi_rready <= 1'b0;
      end
   endtask
   // Poll the serial flag; a bounded count so a missing flag fails
   task wait_flag;
      integer k;
      begin
         rd = 32'h0;
         for (k = 0; k < 400 && rd[`IRQ_SERIAL_BIT] !== 1'b1; k = k + 1)
            axi_rd(`OFS_IRQ_STATUS);
         `CHK("serial flag", 1'b1, rd[`IRQ_SERIAL_BIT])
      end
   endtask
   // State after a byte and its acknowledge
   task chk_byte(input adr, input [7:0] sent, input nak);
      begin
         axi_rd(`OFS_CONTROL2);
         `CHK("ack status", exp_ack(adr, sent, nak), rd[`CTL_ACK_STAT_BIT])
         axi_rd(`OFS_STATUS);
         `CHK("full flag", 1'b0, rd[`STAT_BF_BIT])
         `CHK("byte on wire", sent, rx_byte)
         `CHK("hold wires", 2'b10, {scl_oe, sda_oe})
         axi_wr(`OFS_IRQ_STATUS, 32'h3);
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", samples_checked, err_total);
         if (err_total == 0 && samples_checked > 0)
            $display("TB: PASS");
         else
            $display("TB: FAIL");
         $finish;
      end
   endtask
   // Cut a hang short
   always @(posedge sys_clk)
   begin
      cycles = cycles + 1;
      if (cycles == 40000)
      begin
         err_total = err_total + 1;
         conclude;
      end
   end
   ////////////////////////////////////////
   initial
   begin
      repeat (12) @(posedge sys_clk);
      nrst <= 1'b1;
      axi_rd(`OFS_BAUD_RELOAD);
      `CHK("reload reset", `BAUD_RELOAD_RST, rd[7:0])
      axi_rd(8'h3C);
      `CHK("bad read", `RESP_SLVERR, rs)
      axi_wr(8'h40, 32'h1);
      `CHK("bad write", `RESP_SLVERR, rs)
      // Lane 0 strobe clear: answered OKAY, register left alone
      s_axi_wstrb <= 4'h0;
      axi_wr(`OFS_BAUD_RELOAD, 32'hEE);
      `CHK("unstrobed resp", `RESP_OKAY, rs)
      s_axi_wstrb <= 4'hF;
      axi_rd(`OFS_BAUD_RELOAD);
      `CHK("reload kept", `BAUD_RELOAD_RST, rd[7:0])
      b = 8'h01 + 8'({$random(seed)} % 3);
      axi_wr(`OFS_BAUD_RELOAD, {24'h0, b});
      axi_wr(`OFS_IRQ_MASK, 32'h1);
      axi_wr(`OFS_CONTROL2, 32'h1 << `CTL_START_BIT);
      wait_flag;
      `CHK("irq raised", 1'b1, irq)
      `CHK("start hold", 2'b11, {scl_oe, sda_oe})
      axi_wr(`OFS_IRQ_STATUS, 32'h1);
      repeat (2) @(posedge sys_clk);
      `CHK("irq cleared", 1'b0, irq)
      // Address byte, then a colliding write while it shifts
      b = addr_byte(SLV_ADDR, 1'b0);
      axi_wr(`OFS_TX_BUFFER, {24'h0, b});
      axi_rd(`OFS_STATUS);
      `CHK("full set", 1'b1, rd[`STAT_BF_BIT])
      axi_wr(`OFS_TX_BUFFER, 32'h5A);
      axi_rd(`OFS_IRQ_STATUS);
      `CHK("collision", 1'b1, rd[`IRQ_WRITE_COLLISION_FLAG_BIT])
      axi_rd(`OFS_TX_BUFFER);
      `CHK("buffer kept", b, rd[7:0])
      wait_flag;
      chk_byte(1'b1, b, 1'b0);
      // Data bytes; the last one is refused by the slave
      for (i = 0; i < 4; i = i + 1)
      begin
         b = 8'($random(seed));
         slv_nack <= (i == 3);
         axi_wr(`OFS_TX_BUFFER, {24'h0, b});
         wait_flag;
         chk_byte(1'b0, b, i == 3);
      end
      // Masked restart, then an address nobody answers
      axi_wr(`OFS_IRQ_MASK, 32'h0);
      axi_wr(`OFS_CONTROL2, 32'h1 << `CTL_RESTART_BIT);
      wait_flag;
      `CHK("irq masked", 1'b0, irq)
      axi_wr(`OFS_IRQ_STATUS, 32'h1);
      b = addr_byte(SLV_ADDR ^ 7'h01, 1'b0);
      axi_wr(`OFS_TX_BUFFER, {24'h0, b});
      wait_flag;
      chk_byte(1'b1, b, 1'b0);
      axi_wr(`OFS_CONTROL2, 32'h1 << `CTL_STOP_BIT);
      wait_flag;
      `CHK("bus released", 2'b00, {scl_oe, sda_oe})
      axi_rd(`OFS_STATUS);
      `CHK("idle", 1'b0, rd[`STAT_BUSY_BIT])
      conclude;
   end
endmodule // test_i2c_master_transmit
